// ---- sfx_pkg.sv ----
// Shared constants, strap codes, modes and decode for the FIFO bank and its user logic.
// Assumes one clock drives both ends; write, read and transfer clocks are all clk.
package sfx_pkg;

  // ==========================================================================
  // Geometry
  localparam int DATA_W = 18;                         // Word width
  localparam int ADDR_W = 8;                          // Memory address width
  localparam int CNT_W  = 9;                          // Occupancy counter width
  localparam logic [CNT_W-1:0] DEPTH_CNT  = 9'h100;   // Words held in the array
  localparam logic [CNT_W-1:0] HALF_CNT   = 9'h080;   // Half-full threshold
  localparam logic [CNT_W-1:0] AE_OFFSET  = 9'h007;   // Default almost-empty offset
  localparam logic [CNT_W-1:0] AF_OFFSET  = 9'h007;   // Default almost-full offset
  localparam logic [ADDR_W-1:0] LAST_ADDR = 8'hff;    // Last physical location

  // ==========================================================================
  // Strap codes, ordered {first_load, read_chain_in, write_chain_in}
  localparam logic [2:0] CFG_DBL_A   = 3'h2;
  localparam logic [2:0] CFG_DBL_B   = 3'h6;
  localparam logic [2:0] CFG_FALL_THROUGH_MODE_A  = 3'h1;
  localparam logic [2:0] CFG_FALL_THROUGH_MODE_B  = 3'h5;
  localparam logic [2:0] CFG_DAISY_A = 3'h3;
  localparam logic [2:0] CFG_DAISY_B = 3'h7;
  localparam logic [2:0] CFG_SPF_A   = 3'h4;          // Synchronous partial flags
  localparam logic [2:0] CFG_SPF_B   = 3'h5;
  localparam logic [2:0] CFG_SPF_C   = 3'h6;

  // ==========================================================================
  // Operating modes, one-hot
  typedef enum logic [3:0] {
    MODE_STD_SINGLE = 4'h1,
    MODE_STD_DOUBLE = 4'h2,
    MODE_FALL_THROUGH_MODE       = 4'h4,
    MODE_DAISY      = 4'h8
  } sfx_mode_t;

  // Map a strap pattern to its flag and timing mode
  function automatic sfx_mode_t sfx_decode(input logic [2:0] s);
    sfx_mode_t m;
    case (s)
      CFG_DBL_A, CFG_DBL_B:     m = MODE_STD_DOUBLE;
      CFG_FALL_THROUGH_MODE_A, CFG_FALL_THROUGH_MODE_B:   m = MODE_FALL_THROUGH_MODE;
      CFG_DAISY_A, CFG_DAISY_B: m = MODE_DAISY;
      default:                  m = MODE_STD_SINGLE;
    endcase
    return m;
  endfunction

  // True when the partial flags run on the clock edge
  function automatic logic sfx_sync_pf(input logic [2:0] s);
    return (s == CFG_SPF_A) || (s == CFG_SPF_B) || (s == CFG_SPF_C);
  endfunction

endpackage

// ---- sfx_fifo_if.sv ----
// Pin bundle of one FIFO bank, shared by the bank and the logic that uses it.
// Assumes all flag, strap and chain pins are active low as on the device.
`timescale 1ns/1ps
interface sfx_fifo_if;
  import sfx_pkg::*;

  // ==========================================================================
  // Data and strobes
  logic [DATA_W-1:0] write_data;           // Word to write
  logic              write_enable_n;       // Write strobe
  logic [DATA_W-1:0] read_data;            // Word read
  logic              read_data_oe;         // Read bus driven
  logic              read_enable_n;        // Read strobe
  logic              output_enable_n;      // Read bus enable
  // Flags
  logic              empty_flag_n;         // Empty, or output-ready in fall-through
  logic              full_flag_n;          // Full, or input-ready in fall-through
  logic              half_full_flag_n;     // More than half full
  logic              almost_empty_flag_n;  // Almost empty
  logic              almost_full_flag_n;   // Almost full
  // Straps and chain
  logic              first_load_select_n;  // First device of a chain
  logic              read_chain_in_n;      // Read token in
  logic              write_chain_in_n;     // Write token in
  logic              read_chain_out_n;     // Read token out
  logic              write_chain_out_n;    // Write token out

  modport dev (
    input  write_data, write_enable_n, read_enable_n, output_enable_n,
    input  first_load_select_n, read_chain_in_n, write_chain_in_n,
    output read_data, read_data_oe, empty_flag_n, full_flag_n, half_full_flag_n,
    output almost_empty_flag_n, almost_full_flag_n, read_chain_out_n, write_chain_out_n
  );

  modport usr (
    output write_data, write_enable_n, read_enable_n, output_enable_n,
    output first_load_select_n, read_chain_in_n, write_chain_in_n,
    input  read_data, read_data_oe, empty_flag_n, full_flag_n, half_full_flag_n,
    input  almost_empty_flag_n, almost_full_flag_n, read_chain_out_n, write_chain_out_n
  );

endinterface

// ---- sfx_fifo_dev.sv ----
// One 18-bit FIFO bank with strap-selected flag timing and expansion modes.
// Assumes write, read and transfer clocks are the single clock clk, so skew slips
// never occur; the strobes and straps come from logic on the same clock.
`timescale 1ns/1ps

// ============================================================================
// Contract
// - Double-buffered full releases one write cycle late
// - Double-buffered empty releases one read cycle late
// - Straps 010 or 110 select double-buffered mode
// - Straps 001 or 101 select fall-through output
// - Other non-chain straps give stand-alone operation
// - User merges ready flags of parallel devices
// - User drives width-expanded controls in common
// - First chained device first-load low, others high
// - Chain outs feed next chain ins; loads tied
// - Half-full flag invalid in daisy chain
// - User ORs flags of all chained devices
// - Daisy chain: single-buffered, asynchronous partial flags
// - Series chain: all fall-through, data cascaded
// - First word ripples through with free clocks
// - Low output-ready marks data, feeds next write
// - Ripple delay only for first word
// - Freed space drives input-ready low
// - Space reaches head within bounded transfer cycles
// - Transfer clock tied to faster clock
// - Synchronous almost-full changes on write edges
module sfx_fifo_dev
  import sfx_pkg::*;
(
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      resetn,
  // Pins of the bank
  sfx_fifo_if.dev        bus,
  // Selected mode, for the user side
  output sfx_mode_t      cfg_mode
);

  // ==========================================================================
  // State
  typedef struct packed {
    sfx_mode_t         mode;       // Mode caught at reset
    logic              sync_pf;    // Partial flags on clock edge
    logic [ADDR_W-1:0] wptr;       // Write address
    logic [ADDR_W-1:0] rptr;       // Read address
    logic [CNT_W-1:0]  cnt;        // Words in the array
    logic              out_valid;  // Fall-through output stage full
    logic [DATA_W-1:0] rdata;      // Output word
    logic              full_q;     // Full one cycle ago
    logic              empty_q;    // Empty one cycle ago
    logic              ae_q;       // Registered almost-empty
    logic              af_q;       // Registered almost-full
    logic              wtok;       // Holds the write token
    logic              rtok;       // Holds the read token
    logic              wxo_n;      // Write token pass pulse
    logic              rxo_n;      // Read token pass pulse
  } sfx_dev_state_t;

  sfx_dev_state_t    st_reg;                       // Registered state
  sfx_dev_state_t    st_next;                      // Next state
  logic [DATA_W-1:0] mem [0:(1 << ADDR_W) - 1];    // Storage array
  logic [2:0]        straps;                       // Strap pins
  logic              full_int;                     // Array full now
  logic              empty_int;                    // Array empty now
  logic              wr_ok;                        // Write accepted
  logic              rd_ok;                        // Standard read accepted
  logic              pop;                          // Fall-through word taken
  logic              load_out;                     // Array word to output stage
  logic              mem_rd;                       // Array read this cycle
  logic [CNT_W-1:0]  occ;                          // Total words held
  logic [CNT_W-1:0]  cap;                          // Total capacity
  logic              ae_now;                       // Almost-empty level now
  logic              af_now;                       // Almost-full level now
  logic              is_fall_through_mode;                      // Fall-through mode
  logic              is_daisy;                     // Daisy chain mode

  assign straps   = {bus.first_load_select_n, bus.read_chain_in_n, bus.write_chain_in_n};
  assign is_fall_through_mode  = (st_reg.mode == MODE_FALL_THROUGH_MODE);
  assign is_daisy = (st_reg.mode == MODE_DAISY);

  // ==========================================================================
  // Occupancy and accept terms
  always_comb
  begin
    full_int  = (st_reg.cnt == DEPTH_CNT);
    empty_int = (st_reg.cnt == '0);
    // A chained device only moves data while it holds the token
    wr_ok     = !bus.write_enable_n && !full_int && (!is_daisy || st_reg.wtok);
    rd_ok     = !is_fall_through_mode && !bus.read_enable_n && !empty_int && (!is_daisy || st_reg.rtok);
    pop       = is_fall_through_mode && !bus.read_enable_n && st_reg.out_valid;
    // Output stage refills itself, so a word falls through with no read
    load_out  = is_fall_through_mode && !empty_int && (!st_reg.out_valid || pop);
    mem_rd    = rd_ok || load_out;
    occ       = st_reg.cnt + CNT_W'(st_reg.out_valid);
    cap       = is_fall_through_mode ? DEPTH_CNT + CNT_W'(1) : DEPTH_CNT;
    ae_now    = (occ <= AE_OFFSET);
    af_now    = (occ >= cap - AF_OFFSET);
  end

  // ==========================================================================
  // Next state
  always_comb
  begin
    st_next = st_reg;
    if (!resetn)
    begin
      // Straps are caught on every edge while reset is held; the last one wins
      st_next         = '0;
      st_next.mode    = sfx_decode(straps);
      st_next.sync_pf = sfx_decode(straps) != MODE_DAISY
                        && sfx_sync_pf(straps);
      st_next.wtok    = !bus.first_load_select_n;
      st_next.rtok    = !bus.first_load_select_n;
      st_next.empty_q = 1'b1;
      st_next.ae_q    = 1'b1;
      st_next.wxo_n   = 1'b1;
      st_next.rxo_n   = 1'b1;
    end
    else
    begin
      // Pointers and count
      if (wr_ok)
        st_next.wptr = st_reg.wptr + ADDR_W'(1);
      if (mem_rd)
        st_next.rptr = st_reg.rptr + ADDR_W'(1);
      st_next.cnt = st_reg.cnt + CNT_W'(wr_ok) - CNT_W'(mem_rd);
      // Output word always comes from a register
      if (mem_rd)
        st_next.rdata = mem[st_reg.rptr];
      // Fall-through stage
      if (load_out)
        st_next.out_valid = 1'b1;
      else if (pop)
        st_next.out_valid = 1'b0;
      // History for the late release of double-buffered flags
      st_next.full_q  = full_int;
      st_next.empty_q = empty_int;
      // Synchronous partial flags move only on the clock edge
      st_next.ae_q = ae_now;
      st_next.af_q = af_now;
      // Daisy tokens: pass after the last location, take on a chain-in pulse
      st_next.wxo_n = 1'b1;
      st_next.rxo_n = 1'b1;
      if (is_daisy)
      begin
        if (wr_ok && st_reg.wptr == LAST_ADDR)
        begin
          st_next.wtok  = 1'b0;
          st_next.wxo_n = 1'b0;
        end
        else if (!bus.write_chain_in_n)
          st_next.wtok = 1'b1;
        if (rd_ok && st_reg.rptr == LAST_ADDR)
        begin
          st_next.rtok  = 1'b0;
          st_next.rxo_n = 1'b0;
        end
        else if (!bus.read_chain_in_n)
          st_next.rtok = 1'b1;
      end
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk)
  begin
    st_reg <= st_next;
  end

  // Storage array has no reset; its contents are don't-care until written
  always_ff @(posedge clk)
  begin
    if (resetn && wr_ok)
      mem[st_reg.wptr] <= bus.write_data;
  end

  // ==========================================================================
  // Flag pins
  always_comb
  begin
    case (st_reg.mode)
      MODE_FALL_THROUGH_MODE:
      begin
        // Low output-ready means the output word is valid
        bus.empty_flag_n = !st_reg.out_valid;
        // Input-ready drops as soon as a pop frees space
        bus.full_flag_n  = full_int;
      end
      MODE_STD_DOUBLE:
      begin
        // Assert at once, release one cycle after the freeing edge
        bus.empty_flag_n = !(empty_int || st_reg.empty_q);
        bus.full_flag_n  = !(full_int || st_reg.full_q);
      end
      default:
      begin
        // Single-buffered, also used in the daisy chain
        bus.empty_flag_n = !empty_int;
        bus.full_flag_n  = !full_int;
      end
    endcase
    // FALL_THROUGH_MODE flag polarity: low input-ready means room, so invert the full term
    if (is_fall_through_mode)
      bus.full_flag_n = full_int;
    // Half-full has no meaning when the depth spans several devices
    bus.half_full_flag_n    = is_daisy ? 1'b1 : !(occ > HALF_CNT);
    bus.almost_empty_flag_n = !(st_reg.sync_pf ? st_reg.ae_q : ae_now);
    bus.almost_full_flag_n  = !(st_reg.sync_pf ? st_reg.af_q : af_now);
  end

  // ==========================================================================
  // Data and chain pins
  assign bus.read_data         = st_reg.rdata;
  assign bus.read_data_oe      = !bus.output_enable_n;
  assign bus.write_chain_out_n = st_reg.wxo_n;
  assign bus.read_chain_out_n  = st_reg.rxo_n;
  assign cfg_mode              = st_reg.mode;

endmodule

// ---- sfx_fifo_usr.sv ----
// Logic that writes and reads one FIFO bank and merges its flags.
// Assumes the bank shares clk; a daisy chain of one device loops its chain outs to its ins.
`timescale 1ns/1ps
module sfx_fifo_usr
  import sfx_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // Pins of the bank
  sfx_fifo_if.usr                bus,
  // Strap choice, held steady through reset
  input  wire logic              first_in_chain,
  input  wire logic              strap_read_chain_n,
  input  wire logic              strap_write_chain_n,
  // Write stream
  input  wire logic              wr_valid,
  input  wire logic [DATA_W-1:0] wr_data,
  output logic                   wr_ready,
  // Read stream
  output logic                   rd_valid,
  output logic [DATA_W-1:0]      rd_data,
  input  wire logic              rd_ready,
  // Composite status, active high
  output logic                   empty_any,
  output logic                   full_any,
  output logic                   almost_empty_any,
  output logic                   almost_full_any
);

  // ==========================================================================
  // State
  typedef struct packed {
    sfx_mode_t         mode;     // Mode the bank was strapped into
    logic              pend;     // Standard read issued, word next cycle
    logic              valid;    // Output slot full
    logic [DATA_W-1:0] data;     // Output slot
  } sfx_usr_state_t;

  sfx_usr_state_t st_reg;   // Registered state
  sfx_usr_state_t st_next;  // Next state
  logic           slot_ok;  // Slot can take a word
  logic           take;     // Read strobe this cycle
  logic           fall_through_mode;     // Fall-through mode
  logic           chain_ring; // Chain pins looped back after reset

  assign fall_through_mode    = (st_reg.mode == MODE_FALL_THROUGH_MODE);
  assign chain_ring = resetn && (st_reg.mode == MODE_DAISY);
  assign slot_ok = !st_reg.valid || rd_ready;

  // ==========================================================================
  // Pins toward the bank
  always_comb
  begin
    // The first chained device grounds first-load, others hold it high
    bus.first_load_select_n = !first_in_chain;
    // A lone chained bank is its own neighbour: each token pulse comes straight back
    bus.read_chain_in_n     = chain_ring ? bus.read_chain_out_n : strap_read_chain_n;
    bus.write_chain_in_n    = chain_ring ? bus.write_chain_out_n : strap_write_chain_n;
    bus.output_enable_n     = 1'b0;
    // Fall-through output-ready doubles as the strobe for a follower
    if (fall_through_mode)
      take = !bus.empty_flag_n && slot_ok;
    else
      take = bus.empty_flag_n && slot_ok && !st_reg.pend;
    bus.read_enable_n  = !(take && resetn);
    // Controls of paralleled banks would share these same strobes
    // The write token is away while its pass pulse is out, so there is no room then
    wr_ready           = (fall_through_mode ? !bus.full_flag_n : bus.full_flag_n) && bus.write_chain_out_n;
    bus.write_enable_n = !(wr_valid && wr_ready && resetn);
    bus.write_data     = wr_data;
  end

  // ==========================================================================
  // Read slot and mode tracking
  always_comb
  begin
    st_next = st_reg;
    if (!resetn)
    begin
      st_next      = '0;
      st_next.mode = sfx_decode({!first_in_chain, strap_read_chain_n, strap_write_chain_n});
    end
    else
    begin
      if (rd_ready)
        st_next.valid = 1'b0;
      // Fall-through word is on the pins now; standard word lands next cycle
      st_next.pend = !fall_through_mode && take;
      if ((fall_through_mode && take) || st_reg.pend)
      begin
        st_next.valid = 1'b1;
        st_next.data  = bus.read_data;
      end
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk)
  begin
    st_reg <= st_next;
  end

  // ==========================================================================
  // Outputs; merged flags stay correct when more banks are ORed in
  assign rd_valid         = st_reg.valid;
  assign rd_data          = st_reg.data;
  assign empty_any        = fall_through_mode ? bus.empty_flag_n : !bus.empty_flag_n;
  assign full_any         = fall_through_mode ? bus.full_flag_n : !bus.full_flag_n;
  assign almost_empty_any = !bus.almost_empty_flag_n;
  assign almost_full_any  = !bus.almost_full_flag_n;

endmodule

// ---- sfx_fifo_chk.sv ----
// Checker for one FIFO bank: strap decode, mode hold and flag timing.
// Assumes the bench wires it to the pin bundle; everything runs on clk.
`timescale 1ns/1ps
module sfx_fifo_chk
  import sfx_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              resetn,
  // Data and strobes
  input wire logic [DATA_W-1:0] write_data,
  input wire logic              write_enable_n,
  input wire logic [DATA_W-1:0] read_data,
  input wire logic              read_enable_n,
  // Flags
  input wire logic              empty_flag_n,
  input wire logic              full_flag_n,
  input wire logic              half_full_flag_n,
  input wire logic              almost_full_flag_n,
  // Straps and mode
  input wire logic              first_load_select_n,
  input wire logic              read_chain_in_n,
  input wire logic              write_chain_in_n,
  input sfx_mode_t              cfg_mode
);
  // ==========================================================================
  // Helper state
  logic [2:0] strap_reg;   // Strap code at the last reset edge
  logic [2:0] strap_next;  // Next strap code
  logic       dbl;         // Double-buffered flags
  logic       fall_through_mode;        // Fall-through output
  logic       one;         // Single-buffered flags
  logic       spf;         // Clocked partial flags
  // Capture straps only in reset, so a later pin change cannot move it
  always_comb
  begin
    strap_next = resetn ? strap_reg : {first_load_select_n, read_chain_in_n, write_chain_in_n};
  end
  always_ff @(posedge clk)
  begin
    strap_reg <= strap_next;
  end
  assign dbl  = (cfg_mode == MODE_STD_DOUBLE);
  assign fall_through_mode = (cfg_mode == MODE_FALL_THROUGH_MODE);
  assign one  = (cfg_mode == MODE_STD_SINGLE) || (cfg_mode == MODE_DAISY);
  assign spf  = (strap_reg == 3'h4) || (strap_reg == 3'h5) || (strap_reg == 3'h6);

  // Own decode table, kept apart from the bank's
  function automatic sfx_mode_t want_mode(input logic [2:0] s);
    case (s)
      3'h1, 3'h5: return MODE_FALL_THROUGH_MODE;
      3'h2, 3'h6: return MODE_STD_DOUBLE;
      3'h3, 3'h7: return MODE_DAISY;
      default:    return MODE_STD_SINGLE;
    endcase
  endfunction

  // ==========================================================================
  // Properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // Flag stays asserted one more cycle, then releases
  sequence s_late(f);
    !f ##1 f;
  endsequence
  // Word reaches the outputs two cycles after its write edge
  sequence s_fall;
    empty_flag_n ##1 (!empty_flag_n && read_data == $past(write_data, 2));
  endsequence

  a_mode_held: assert property ($past(resetn) |-> $stable(cfg_mode))
    else $error("mode moved outside reset");
  a_strap_decode: assert property ($rose(resetn) |-> cfg_mode == want_mode(strap_reg))
    else $error("mode does not match straps");
  a_full_double: assert property (dbl && !full_flag_n && !read_enable_n && write_enable_n |=> s_late(full_flag_n))
    else $error("double full release off");
  // A write after an idle cycle with the flag low lands in an empty bank
  a_empty_double: assert property (dbl && !empty_flag_n && !write_enable_n && $past(write_enable_n)
    |=> s_late(empty_flag_n))
    else $error("double empty release off");
  a_empty_single: assert property (one && !empty_flag_n && !write_enable_n |=> empty_flag_n)
    else $error("single empty release off");
  a_fall_through: assert property (fall_through_mode && empty_flag_n && !write_enable_n && $past(write_enable_n)
    && $past(write_enable_n, 2) |=> s_fall)
    else $error("first word did not fall through");
  a_ready_hold: assert property (fall_through_mode && !empty_flag_n && read_enable_n |=> !empty_flag_n && $stable(read_data))
    else $error("ready word lost without read");
  a_half_daisy: assert property (cfg_mode == MODE_DAISY |-> half_full_flag_n)
    else $error("half full asserted in chain mode");
  a_af_sync: assert property (spf && $past(resetn) && $changed(almost_full_flag_n) |-> !$past(write_enable_n)
    || !$past(read_enable_n) || !$past(write_enable_n, 2) || !$past(read_enable_n, 2))
    else $error("almost full moved without a strobe");
endmodule

// ---- sfx_fifo_tb.sv ----
// Bench for one FIFO bank and its user logic joined by the pin bundle.
// Assumes a 200 MHz clk; each strap code gets a reset, and every code but 7 also gets a fill and a drain.
`timescale 1ns/1ps
module sfx_fifo_tb;
  import sfx_pkg::*;

  // ==========================================================================
  // Bench signals
  logic              clk;
  logic              resetn;
  logic              first_in_chain;
  logic              strap_read_chain_n;
  logic              strap_write_chain_n;
  logic              wr_valid;
  logic [DATA_W-1:0] wr_data;
  logic              wr_ready;
  logic              rd_valid;
  logic [DATA_W-1:0] rd_data;
  logic              rd_ready;
  logic              empty_any;
  logic              full_any;
  logic              almost_empty_any;
  logic              almost_full_any;
  sfx_mode_t         cfg_mode;
  int                num_errors;
  int                tests_run;
  int                cycles;
  // Expected mode per code {first_load, read_chain, write_chain}
  sfx_mode_t exp_mode [8] = '{MODE_STD_SINGLE, MODE_FALL_THROUGH_MODE, MODE_STD_DOUBLE, MODE_DAISY,
                             MODE_STD_SINGLE, MODE_FALL_THROUGH_MODE, MODE_STD_DOUBLE, MODE_DAISY};

  sfx_fifo_if bus_if ();
  sfx_fifo_dev sfx_fifo_dev_i (.clk(clk), .resetn(resetn), .bus(bus_if.dev), .cfg_mode(cfg_mode));
  sfx_fifo_usr sfx_fifo_usr_i (.clk(clk), .resetn(resetn), .bus(bus_if.usr), .first_in_chain(first_in_chain),
    .strap_read_chain_n(strap_read_chain_n), .strap_write_chain_n(strap_write_chain_n), .wr_valid(wr_valid),
    .wr_data(wr_data), .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_data(rd_data), .rd_ready(rd_ready),
    .empty_any(empty_any), .full_any(full_any), .almost_empty_any(almost_empty_any),
    .almost_full_any(almost_full_any));
  sfx_fifo_chk sfx_fifo_chk_i (.clk(clk), .resetn(resetn), .write_data(bus_if.write_data),
    .write_enable_n(bus_if.write_enable_n), .read_data(bus_if.read_data), .read_enable_n(bus_if.read_enable_n),
    .empty_flag_n(bus_if.empty_flag_n), .full_flag_n(bus_if.full_flag_n),
    .half_full_flag_n(bus_if.half_full_flag_n), .almost_full_flag_n(bus_if.almost_full_flag_n),
    .first_load_select_n(bus_if.first_load_select_n), .read_chain_in_n(bus_if.read_chain_in_n),
    .write_chain_in_n(bus_if.write_chain_in_n), .cfg_mode(cfg_mode));

  // ==========================================================================
  // Clock and hang guard; the sweep needs about 5k cycles
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      num_errors++;
      summarize();
    end
  end

  // ==========================================================================
  // Compare tasks and closing report
  task automatic check_data(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_flag(input string what, input logic exp, input logic got);
    check_data(what, {17'h0_0000, exp}, {17'h0_0000, got});
  endtask
  task automatic check_mode(input string what, input sfx_mode_t exp, input sfx_mode_t got);
    check_data(what, {14'h0000, exp}, {14'h0000, got});
  endtask
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================================
  // Reset with straps held steady across all reset edges
  task automatic apply_reset(input logic [2:0] code);
    @(posedge clk);
    #1 resetn = 1'b0;
    first_in_chain = ~code[2];
    strap_read_chain_n = code[1];
    strap_write_chain_n = code[0];
    repeat (16) @(posedge clk);
    #1 resetn = 1'b1;
  endtask
  // Stream a counter until the bank stops taking words; data holds while refused
  task automatic fill(input logic [2:0] code, output int n);
    int idle;
    n = 0;
    idle = 0;
    wr_valid = 1'b1;
    wr_data = {code, 15'h0000};
    while (idle < 8 && n < 300)
    begin
      @(posedge clk);
      idle = (wr_ready === 1'b1) ? 0 : idle + 1;
      n = (wr_ready === 1'b1) ? n + 1 : n;
      #1 wr_data = {code, 15'(n)};
    end
    wr_valid = 1'b0;
  endtask
  // Take every word with no stall and check arrival order
  task automatic drain(input logic [2:0] code, input int n);
    int k;
    int idle;
    k = 0;
    idle = 0;
    rd_ready = 1'b1;
    while (k < n && idle < 16)
    begin
      @(posedge clk);
      idle++;
      if (rd_valid === 1'b1)
      begin
        check_data("read word", {code, 15'(k)}, rd_data);
        k++;
        idle = 0;
      end
    end
    #1 rd_ready = 1'b0;
    check_flag("all words back", 1'b1, k == n);
  endtask

  // ==========================================================================
  // Sweep every strap code
  initial
  begin
    int n;
    resetn = 1'b0;
    first_in_chain = 1'b1;
    strap_read_chain_n = 1'b1;
    strap_write_chain_n = 1'b1;
    wr_valid = 1'b0;
    wr_data = '0;
    rd_ready = 1'b0;
    for (int c = 0; c < 8; c++)
    begin
      apply_reset(3'(c));
      check_mode("mode", exp_mode[c], cfg_mode);
      // Chain codes skip the strap flip: those pins carry tokens there
      if (c[1:0] != 2'h3)
      begin
        first_in_chain = c[2];
        strap_read_chain_n = ~c[1];
        repeat (4) @(posedge clk);
        #1 check_mode("mode held", exp_mode[c], cfg_mode);
        first_in_chain = ~c[2];
        strap_read_chain_n = c[1];
      end
      // A lone non-first chain device never gets a token, so no traffic
      if (c != 7)
      begin
        fill(3'(c), n);
        check_flag("full", 1'b1, full_any);
        check_flag("almost full", 1'b1, almost_full_any);
        check_flag("half full pin", exp_mode[c] == MODE_DAISY, bus_if.half_full_flag_n);
        check_flag("depth", 1'b1, (n - ((exp_mode[c] == MODE_FALL_THROUGH_MODE) ? 257 : 256)) inside {0, 1});
        drain(3'(c), n);
        repeat (4) @(posedge clk);
        #1 check_flag("empty", 1'b1, empty_any);
        check_flag("almost empty", 1'b1, almost_empty_any);
        check_flag("not full", 1'b0, full_any);
      end
    end
    summarize();
  end
endmodule
